// [core/dtcc_top.sv]
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module dtcc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLK,
	input  wire logic              RESET,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              HSO_TICK,
	input  wire logic              EXT_CLK_PIN,
	input  wire logic [1:0]        EVENT_LINK_IN,
	input  wire logic [3:0]        CCP_IN,
	output logic      [3:0]        CCP_OUT,
	output logic      [3:0]        CCP_OE,
	output logic                   IRQ
);
	localparam int W = dtcc_pkg::CNT_W;

	// all state of the block
	typedef struct packed {
		logic [1:0]                            run;      // channel_run_bit per channel
		logic [1:0]                            ssel;     // stop_select_bit per channel
		logic                                  sync;     // channel_sync_bit
		logic [1:0][dtcc_pkg::CTRL_W-1:0]      ctrl;     // channel_control_register
		logic [1:0][dtcc_pkg::IOC_W-1:0]       ioc;      // pin control
		logic [1:0][W-1:0]                     cnt;      // channel_counter
		logic [3:0][W-1:0]                     gr;       // A0, B0, A1, B1
		logic [1:0][W-1:0]                     bufr;     // capture buffers
		logic [3:0]                            outv;     // compare output levels
		logic [dtcc_pkg::ST_W-1:0]             stat;     // sticky events
		logic [dtcc_pkg::ST_W-1:0]             mask;     // interrupt enables
		logic [dtcc_pkg::PRE_W-1:0]            pre;      // free prescaler
		logic                                  ext_prev; // last external clock sample
		logic [31:0]                           rdata;    // read data held for the access phase
	} dtcc_state_t;

	dtcc_state_t               st_reg;    // current state
	dtcc_state_t               st_next;   // next state
	logic [3:0]                edge_ev;   // filtered pin edges
	logic [3:0]                cap_c;     // capture events per general register
	logic [1:0]                tick_c;    // count source tick per channel
	logic [1:0]                adv_c;     // channel counts this cycle
	logic [1:0]                ma_c;      // compare match on register A
	logic [1:0]                mb_c;      // compare match on register B
	logic [1:0]                clr_c;     // own clear request
	logic                      wrap;      // counter returns to zero
	logic [31:0]               rd_val;    // read mux
	logic [dtcc_pkg::ST_W-1:0] w1c;       // status bits software clears
	logic [dtcc_pkg::ST_W-1:0] set_ev;    // status bits hardware sets
	logic                      ext_rise;  // external clock rising edge
	logic                      ext_fall;  // external clock falling edge
	logic                      wr_acc;    // write access phase
	logic [2:0]                cclr;      // clear select of the channel in hand

	// one tick of the selected count source
	function automatic logic src_tick(input logic [2:0] cks, input logic [dtcc_pkg::PRE_W-1:0] pre,
		input logic hso, input logic rise, input logic fall, input logic [1:0] edg);
		logic t;
		t = 1'b0;
		case (cks)
			dtcc_pkg::CKS_CLK:   t = 1'b1;
			dtcc_pkg::CKS_DIV2:  t = pre[0];
			dtcc_pkg::CKS_DIV4:  t = &pre[1:0];
			dtcc_pkg::CKS_DIV8:  t = &pre[2:0];
			dtcc_pkg::CKS_DIV32: t = &pre;
			dtcc_pkg::CKS_HSO:   t = hso;
			dtcc_pkg::CKS_EXT:   t = (edg == dtcc_pkg::EDGE_RISE) ? rise :
				(edg == dtcc_pkg::EDGE_FALL) ? fall : (edg == dtcc_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;
			default:             t = 1'b0; // code 7 is unused: channel idles
		endcase
		return t;
	endfunction

	// new level of a compare output after a match
	function automatic logic apply_act(input logic [1:0] act, input logic cur);
		logic v;
		v = cur;
		case (act)
			dtcc_pkg::ACT_LOW:  v = 1'b0;
			dtcc_pkg::ACT_HIGH: v = 1'b1;
			dtcc_pkg::ACT_TOG:  v = ~cur;
			default:            v = cur;
		endcase
		return v;
	endfunction

	// decoded addresses; anything else answers with an error
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		logic h;
		h = 1'b0;
		case (8'(a))
			dtcc_pkg::OFS_START, dtcc_pkg::OFS_MODE, dtcc_pkg::OFS_CTRL0, dtcc_pkg::OFS_CTRL1,
			dtcc_pkg::OFS_IOC0, dtcc_pkg::OFS_IOC1, dtcc_pkg::OFS_CNT0, dtcc_pkg::OFS_CNT1,
			dtcc_pkg::OFS_GRA0, dtcc_pkg::OFS_GRB0, dtcc_pkg::OFS_GRA1, dtcc_pkg::OFS_GRB1,
			dtcc_pkg::OFS_STAT, dtcc_pkg::OFS_MASK, dtcc_pkg::OFS_BUF0, dtcc_pkg::OFS_BUF1: h = 1'b1;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// capture pins: filter and edge select live in the pin block
	dtcc_pin_edge #(
		.N    (4),
		.FLEN (dtcc_pkg::FILT_LEN)
	) i_dtcc_pin_edge (
		.clk      (CLK),
		.reset    (RESET),
		.pin_in   (CCP_IN),
		.filt_en  ({{2{st_reg.ioc[1][dtcc_pkg::FILT_POS]}}, {2{st_reg.ioc[0][dtcc_pkg::FILT_POS]}}}),
		.edge_sel ({st_reg.ioc[1][dtcc_pkg::EDGEB_POS +: 2], st_reg.ioc[1][dtcc_pkg::EDGEA_POS +: 2],
			st_reg.ioc[0][dtcc_pkg::EDGEB_POS +: 2], st_reg.ioc[0][dtcc_pkg::EDGEA_POS +: 2]}),
		.edge_ev  (edge_ev)
	);

	assign wr_acc = PSEL & PENABLE & PWRITE;

	// counting, compare, capture and the register file
	always_comb begin
		st_next     = st_reg;
		rd_val      = 32'h0;
		w1c         = '0;
		set_ev      = '0;
		wrap        = 1'b0;
		cclr        = dtcc_pkg::CCLR_FREE;
		tick_c      = 2'h0;
		adv_c       = 2'h0;
		ma_c        = 2'h0;
		mb_c        = 2'h0;
		clr_c       = 2'h0;
		cap_c       = 4'h0;
		ext_rise    = EXT_CLK_PIN & ~st_reg.ext_prev;
		ext_fall    = ~EXT_CLK_PIN & st_reg.ext_prev;
		st_next.pre = st_reg.pre + 5'h01;
		st_next.ext_prev = EXT_CLK_PIN;
		// matches first, so that a sync clear can see the other channel
		for (int c = 0; c < 2; c++) begin
			tick_c[c] = src_tick(st_reg.ctrl[c][dtcc_pkg::CKS_POS +: 3], st_reg.pre, HSO_TICK,
				ext_rise, ext_fall, st_reg.ctrl[c][dtcc_pkg::XEDGE_POS +: 2]);
			adv_c[c] = st_reg.run[c] & tick_c[c];
			// a register in capture use never matches
			ma_c[c] = adv_c[c] & ~st_reg.ioc[c][dtcc_pkg::CAPA_POS] & (st_reg.cnt[c] == st_reg.gr[2*c]);
			mb_c[c] = adv_c[c] & ~st_reg.ioc[c][dtcc_pkg::CAPB_POS] & (st_reg.cnt[c] == st_reg.gr[2*c+1]);
			cclr = st_reg.ctrl[c][dtcc_pkg::CCLR_POS +: 3];
			clr_c[c] = (cclr == dtcc_pkg::CCLR_GRA & ma_c[c]) | (cclr == dtcc_pkg::CCLR_GRB & mb_c[c]);
		end
		for (int c = 0; c < 2; c++) begin
			cclr = st_reg.ctrl[c][dtcc_pkg::CCLR_POS +: 3];
			wrap = clr_c[c] | (cclr == dtcc_pkg::CCLR_SYNC & clr_c[1-c]);
			if (ma_c[c] && !st_reg.ssel[c]) begin
				// stop at match A: count is held, the output keeps the match level
				st_next.run[c] = 1'b0;
			end else if (adv_c[c]) begin
				if (wrap) begin
					st_next.cnt[c] = '0;
				end else begin
					st_next.cnt[c] = st_reg.cnt[c] + 16'h0001;
					// only a natural wrap counts as overflow, a match clear does not
					if (st_reg.cnt[c] == 16'hffff) begin
						set_ev[3*c + dtcc_pkg::ST_OVF] = 1'b1;
					end
				end
			end
			// compare outputs
			if (ma_c[c]) begin
				st_next.outv[2*c] = apply_act(st_reg.ioc[c][dtcc_pkg::ACTA_POS +: 2], st_reg.outv[2*c]);
				set_ev[3*c + dtcc_pkg::ST_A] = 1'b1;
			end
			if (mb_c[c]) begin
				st_next.outv[2*c+1] = apply_act(st_reg.ioc[c][dtcc_pkg::ACTB_POS +: 2], st_reg.outv[2*c+1]);
				set_ev[3*c + dtcc_pkg::ST_B] = 1'b1;
			end
			// captures: register A also takes the event link
			cap_c[2*c] = st_reg.ioc[c][dtcc_pkg::CAPA_POS] & (edge_ev[2*c] |
				(st_reg.ioc[c][dtcc_pkg::ELCEN_POS] & EVENT_LINK_IN[c]));
			cap_c[2*c+1] = st_reg.ioc[c][dtcc_pkg::CAPB_POS] & edge_ev[2*c+1];
			if (cap_c[2*c]) begin
				// buffered mode keeps the previous capture for software
				if (st_reg.ctrl[c][dtcc_pkg::BUFEN_POS]) begin
					st_next.bufr[c] = st_reg.gr[2*c];
				end
				st_next.gr[2*c] = st_reg.cnt[c];
				set_ev[3*c + dtcc_pkg::ST_A] = 1'b1;
			end
			if (cap_c[2*c+1]) begin
				st_next.gr[2*c+1] = st_reg.cnt[c];
				set_ev[3*c + dtcc_pkg::ST_B] = 1'b1;
			end
		end
		// read mux, sampled in the setup cycle
		case (8'(PADDR))
			dtcc_pkg::OFS_START: rd_val = 32'({st_reg.ssel, st_reg.run});
			dtcc_pkg::OFS_MODE:  rd_val = 32'(st_reg.sync);
			dtcc_pkg::OFS_CTRL0: rd_val = 32'(st_reg.ctrl[0]);
			dtcc_pkg::OFS_CTRL1: rd_val = 32'(st_reg.ctrl[1]);
			dtcc_pkg::OFS_IOC0:  rd_val = 32'(st_reg.ioc[0]);
			dtcc_pkg::OFS_IOC1:  rd_val = 32'(st_reg.ioc[1]);
			dtcc_pkg::OFS_CNT0:  rd_val = 32'(st_reg.cnt[0]);
			dtcc_pkg::OFS_CNT1:  rd_val = 32'(st_reg.cnt[1]);
			dtcc_pkg::OFS_GRA0:  rd_val = 32'(st_reg.gr[0]);
			dtcc_pkg::OFS_GRB0:  rd_val = 32'(st_reg.gr[1]);
			dtcc_pkg::OFS_GRA1:  rd_val = 32'(st_reg.gr[2]);
			dtcc_pkg::OFS_GRB1:  rd_val = 32'(st_reg.gr[3]);
			dtcc_pkg::OFS_STAT:  rd_val = 32'(st_reg.stat);
			dtcc_pkg::OFS_MASK:  rd_val = 32'(st_reg.mask);
			dtcc_pkg::OFS_BUF0:  rd_val = 32'(st_reg.bufr[0]);
			dtcc_pkg::OFS_BUF1:  rd_val = 32'(st_reg.bufr[1]);
			default:             rd_val = 32'h0;
		endcase
		if (PSEL && !PENABLE) begin
			st_next.rdata = rd_val;
		end
		// software writes come last so they win over counting and capture; only a status clear loses to a hardware set
		if (wr_acc) begin
			case (8'(PADDR))
				dtcc_pkg::OFS_START: begin
					st_next.run  = PWDATA[dtcc_pkg::RUN_POS +: 2];
					st_next.ssel = PWDATA[dtcc_pkg::SSEL_POS +: 2];
				end
				dtcc_pkg::OFS_MODE:  st_next.sync = PWDATA[dtcc_pkg::SYNC_POS];
				dtcc_pkg::OFS_CTRL0: st_next.ctrl[0] = PWDATA[dtcc_pkg::CTRL_W-1:0];
				dtcc_pkg::OFS_CTRL1: st_next.ctrl[1] = PWDATA[dtcc_pkg::CTRL_W-1:0];
				dtcc_pkg::OFS_IOC0:  st_next.ioc[0] = PWDATA[dtcc_pkg::IOC_W-1:0];
				dtcc_pkg::OFS_IOC1:  st_next.ioc[1] = PWDATA[dtcc_pkg::IOC_W-1:0];
				dtcc_pkg::OFS_CNT0: begin
					st_next.cnt[0] = PWDATA[W-1:0];
					if (st_reg.sync) begin
						st_next.cnt[1] = PWDATA[W-1:0];
					end
				end
				dtcc_pkg::OFS_CNT1: begin
					st_next.cnt[1] = PWDATA[W-1:0];
					if (st_reg.sync) begin
						st_next.cnt[0] = PWDATA[W-1:0];
					end
				end
				dtcc_pkg::OFS_GRA0:  st_next.gr[0] = PWDATA[W-1:0];
				dtcc_pkg::OFS_GRB0:  st_next.gr[1] = PWDATA[W-1:0];
				dtcc_pkg::OFS_GRA1:  st_next.gr[2] = PWDATA[W-1:0];
				dtcc_pkg::OFS_GRB1:  st_next.gr[3] = PWDATA[W-1:0];
				dtcc_pkg::OFS_STAT:  w1c = PWDATA[dtcc_pkg::ST_W-1:0];
				dtcc_pkg::OFS_MASK:  st_next.mask = PWDATA[dtcc_pkg::ST_W-1:0];
				default:             ; // read-only or unmapped: nothing stored
			endcase
		end
		// a hardware set in the clearing cycle survives
		st_next.stat = (st_reg.stat & ~w1c) | set_ev;
	end

	// state register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_reg      <= '0;
			st_reg.ssel <= dtcc_pkg::SSEL_RST;
			st_reg.gr   <= {4{dtcc_pkg::GR_RST}};
		end else begin
			st_reg <= st_next;
		end
	end

	// bus answers: zero wait states, error for unmapped addresses
	assign PRDATA  = st_reg.rdata;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_hit(PADDR);

	// pins drive only in compare use with an action chosen
	assign CCP_OUT   = st_reg.outv;
	assign CCP_OE[0] = ~st_reg.ioc[0][dtcc_pkg::CAPA_POS] &
		(st_reg.ioc[0][dtcc_pkg::ACTA_POS +: 2] != dtcc_pkg::ACT_NONE);
	assign CCP_OE[1] = ~st_reg.ioc[0][dtcc_pkg::CAPB_POS] &
		(st_reg.ioc[0][dtcc_pkg::ACTB_POS +: 2] != dtcc_pkg::ACT_NONE);
	assign CCP_OE[2] = ~st_reg.ioc[1][dtcc_pkg::CAPA_POS] &
		(st_reg.ioc[1][dtcc_pkg::ACTA_POS +: 2] != dtcc_pkg::ACT_NONE);
	assign CCP_OE[3] = ~st_reg.ioc[1][dtcc_pkg::CAPB_POS] &
		(st_reg.ioc[1][dtcc_pkg::ACTB_POS +: 2] != dtcc_pkg::ACT_NONE);
	assign IRQ       = |(st_reg.stat & st_reg.mask);

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	// stop sequence on channel 0: match A with stop select 0 and no bus write
	sequence s_stop0;
		ma_c[0] && !st_reg.ssel[0] && !wr_acc;
	endsequence
	// match A clear on channel 0
	sequence s_clr_a0;
		ma_c[0] && st_reg.ssel[0] && st_reg.ctrl[0][dtcc_pkg::CCLR_POS +: 3] == dtcc_pkg::CCLR_GRA && !wr_acc;
	endsequence

	cnt_read_a: assert property (
		PSEL && !PENABLE && !PWRITE && 8'(PADDR) == dtcc_pkg::OFS_CNT0 |=> PRDATA == 32'($past(st_reg.cnt[0])))
		else $error("counter read data wrong");
	indep_write_a: assert property (
		wr_acc && 8'(PADDR) == dtcc_pkg::OFS_CNT1 && !st_reg.sync && !st_reg.run[0]
			|=> st_reg.cnt[0] == $past(st_reg.cnt[0]))
		else $error("independent write reached other counter");
	sync_write_a: assert property (
		wr_acc && 8'(PADDR) == dtcc_pkg::OFS_CNT0 && st_reg.sync
			|=> st_reg.cnt[0] == $past(PWDATA[W-1:0]) && st_reg.cnt[1] == $past(PWDATA[W-1:0]))
		else $error("sync write did not load both counters");
	free_wrap_a: assert property (
		adv_c[0] && !ma_c[0] && !wr_acc && st_reg.cnt[0] == 16'hffff &&
			st_reg.ctrl[0][dtcc_pkg::CCLR_POS +: 3] == dtcc_pkg::CCLR_FREE
			|=> st_reg.cnt[0] == 16'h0000 && st_reg.stat[dtcc_pkg::ST_OVF]
			##1 (st_reg.stat[dtcc_pkg::ST_OVF] || $past(wr_acc)))
		else $error("free run wrap or overflow flag wrong");
	match_clear_a: assert property (
		s_clr_a0 |=> st_reg.cnt[0] == 16'h0000 && st_reg.stat[dtcc_pkg::ST_A])
		else $error("match A did not clear counter");
	cmp_out_a: assert property (
		ma_c[0] && st_reg.ioc[0][dtcc_pkg::ACTA_POS +: 2] == dtcc_pkg::ACT_HIGH && !wr_acc |=> CCP_OUT[0] && CCP_OE[0])
		else $error("compare output not raised on match");
	start_run_a: assert property (
		wr_acc && 8'(PADDR) == dtcc_pkg::OFS_START && PWDATA[dtcc_pkg::RUN_POS] |=> st_reg.run[0])
		else $error("run bit write did not start channel");
	stop_hold_a: assert property (
		s_stop0 ##1 !wr_acc |=> !st_reg.run[0] && $stable(st_reg.cnt[0]) && $stable(CCP_OUT[0]))
		else $error("channel kept counting after stop match");
	pin_capture_a: assert property (
		cap_c[1] && !wr_acc |=> st_reg.gr[1] == $past(st_reg.cnt[0]) && st_reg.stat[dtcc_pkg::ST_B])
		else $error("pin capture lost");
	link_capture_a: assert property (
		EVENT_LINK_IN[1] && st_reg.ioc[1][dtcc_pkg::CAPA_POS] && st_reg.ioc[1][dtcc_pkg::ELCEN_POS] && !wr_acc
			|=> st_reg.gr[2] == $past(st_reg.cnt[1]) && st_reg.stat[3 + dtcc_pkg::ST_A])
		else $error("event link capture lost");
	div32_tick_a: assert property (
		st_reg.ctrl[0][dtcc_pkg::CKS_POS +: 3] == dtcc_pkg::CKS_DIV32 && tick_c[0]
			|=> (!tick_c[0] || st_reg.ctrl[0][dtcc_pkg::CKS_POS +: 3] != dtcc_pkg::CKS_DIV32) [*8])
		else $error("divide by 32 ticked too often");
endmodule

// [core/dtcc_pkg.sv]
package dtcc_pkg;
	// data path widths and filter length
	localparam int          CNT_W      = 16;          // channel counter width
	localparam int          PRE_W      = 5;           // prescaler width, enough for the /32 tap
	localparam int          FILT_LEN   = 3;           // equal samples a filtered pin must show
	// register byte offsets
	localparam logic [7:0]  OFS_START  = 8'h00;       // start_register
	localparam logic [7:0]  OFS_MODE   = 8'h04;       // timer_mode_register
	localparam logic [7:0]  OFS_CTRL0  = 8'h08;       // channel_control_register, channel 0
	localparam logic [7:0]  OFS_CTRL1  = 8'h0c;       // channel_control_register, channel 1
	localparam logic [7:0]  OFS_IOC0   = 8'h10;       // pin control, channel 0
	localparam logic [7:0]  OFS_IOC1   = 8'h14;       // pin control, channel 1
	localparam logic [7:0]  OFS_CNT0   = 8'h18;       // channel_counter 0
	localparam logic [7:0]  OFS_CNT1   = 8'h1c;       // channel_counter 1
	localparam logic [7:0]  OFS_GRA0   = 8'h20;       // first_general_register, channel 0
	localparam logic [7:0]  OFS_GRB0   = 8'h24;       // second general_compare_register, channel 0
	localparam logic [7:0]  OFS_GRA1   = 8'h28;       // first_general_register, channel 1
	localparam logic [7:0]  OFS_GRB1   = 8'h2c;       // second general_compare_register, channel 1
	localparam logic [7:0]  OFS_STAT   = 8'h30;       // sticky event status, write one to clear
	localparam logic [7:0]  OFS_MASK   = 8'h34;       // interrupt mask
	localparam logic [7:0]  OFS_BUF0   = 8'h38;       // capture buffer, channel 0
	localparam logic [7:0]  OFS_BUF1   = 8'h3c;       // capture buffer, channel 1
	// start_register fields
	localparam int          RUN_POS    = 0;           // channel_run_bit, two bits
	localparam int          SSEL_POS   = 2;           // stop_select_bit, two bits
	localparam logic [1:0]  SSEL_RST   = 2'h3;        // software stop by default
	// timer_mode_register field
	localparam int          SYNC_POS   = 0;           // channel_sync_bit
	// channel_control_register fields
	localparam int          CCLR_POS   = 0;           // clear_select_bit2..0
	localparam int          CKS_POS    = 3;           // count source, three bits
	localparam int          XEDGE_POS  = 6;           // external clock edge, two bits
	localparam int          BUFEN_POS  = 8;           // buffered capture
	localparam int          CTRL_W     = 9;
	// pin control fields
	localparam int          CAPA_POS   = 0;           // pin A used as capture input
	localparam int          CAPB_POS   = 1;           // pin B used as capture input
	localparam int          EDGEA_POS  = 2;           // capture edge of pin A, two bits
	localparam int          EDGEB_POS  = 4;           // capture edge of pin B, two bits
	localparam int          ELCEN_POS  = 6;           // event link may capture into register A
	localparam int          ACTA_POS   = 7;           // compare action of pin A, two bits
	localparam int          ACTB_POS   = 9;           // compare action of pin B, two bits
	localparam int          FILT_POS   = 11;          // digital input filter
	localparam int          IOC_W      = 12;
	// status bits, three per channel
	localparam int          ST_A       = 0;           // capture or match on register A
	localparam int          ST_B       = 1;           // capture or match on register B
	localparam int          ST_OVF     = 2;           // counter overflow
	localparam int          ST_W       = 6;
	localparam logic [15:0] GR_RST     = 16'hffff;    // general registers after reset
	// clear select codes
	localparam logic [2:0]  CCLR_FREE  = 3'h0;
	localparam logic [2:0]  CCLR_GRA   = 3'h1;
	localparam logic [2:0]  CCLR_GRB   = 3'h2;
	localparam logic [2:0]  CCLR_SYNC  = 3'h3;        // clear together with the other channel
	// count source codes
	localparam logic [2:0]  CKS_CLK    = 3'h0;
	localparam logic [2:0]  CKS_DIV2   = 3'h1;
	localparam logic [2:0]  CKS_DIV4   = 3'h2;
	localparam logic [2:0]  CKS_DIV8   = 3'h3;
	localparam logic [2:0]  CKS_DIV32  = 3'h4;
	localparam logic [2:0]  CKS_HSO    = 3'h5;
	localparam logic [2:0]  CKS_EXT    = 3'h6;
	// edge codes
	localparam logic [1:0]  EDGE_RISE  = 2'h0;
	localparam logic [1:0]  EDGE_FALL  = 2'h1;
	localparam logic [1:0]  EDGE_BOTH  = 2'h2;
	localparam logic [1:0]  EDGE_NONE  = 2'h3;
	// compare output actions
	localparam logic [1:0]  ACT_NONE   = 2'h0;
	localparam logic [1:0]  ACT_LOW    = 2'h1;
	localparam logic [1:0]  ACT_HIGH   = 2'h2;
	localparam logic [1:0]  ACT_TOG    = 2'h3;
endpackage

// [core/dtcc_pin_edge.sv]
`timescale 1ns/1ps
// optional digital filter and active edge detection for the capture pins
module dtcc_pin_edge #(
	parameter int N     = 4,
	parameter int FLEN  = dtcc_pkg::FILT_LEN
) (
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire logic [N-1:0]   pin_in,
	input  wire logic [N-1:0]   filt_en,
	input  wire logic [2*N-1:0] edge_sel,
	output logic      [N-1:0]   edge_ev
);
	// all state of the module
	typedef struct packed {
		logic [N-1:0]      samp;  // previous raw sample
		logic [N-1:0][1:0] run;   // count of equal consecutive samples
		logic [N-1:0]      lvl;   // cleaned level
		logic [N-1:0]      ev;    // registered edge pulse
	} dtcc_pe_t;

	dtcc_pe_t st_reg;  // current state
	dtcc_pe_t st_next; // next state

	// filter and edge decision per pin
	always_comb begin
		st_next = st_reg;
		for (int k = 0; k < N; k++) begin
			st_next.samp[k] = pin_in[k];
			if (pin_in[k] == st_reg.samp[k]) begin
				// saturate so a long quiet pin does not wrap the count
				if (st_reg.run[k] != 2'(FLEN - 1)) begin
					st_next.run[k] = st_reg.run[k] + 2'h1;
				end
			end else begin
				st_next.run[k] = 2'h0;
			end
			// the filter costs FLEN-1 cycles of latency; glitches shorter than FLEN cycles vanish
			if (!filt_en[k] || st_next.run[k] == 2'(FLEN - 1)) begin
				st_next.lvl[k] = pin_in[k];
			end
			unique case (edge_sel[2*k +: 2])
				dtcc_pkg::EDGE_RISE: st_next.ev[k] = st_next.lvl[k] & ~st_reg.lvl[k];
				dtcc_pkg::EDGE_FALL: st_next.ev[k] = ~st_next.lvl[k] & st_reg.lvl[k];
				dtcc_pkg::EDGE_BOTH: st_next.ev[k] = st_next.lvl[k] ^ st_reg.lvl[k];
				dtcc_pkg::EDGE_NONE: st_next.ev[k] = 1'b0;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign edge_ev = st_reg.ev;

	// a filtered edge needs the pin steady for three samples
	filt_steady_a: assert property (@(posedge clk) disable iff (reset)
		edge_ev[0] && $past(filt_en[0]) |-> $past(pin_in[0], 1) == $past(pin_in[0], 2) &&
			$past(pin_in[0], 2) == $past(pin_in[0], 3))
		else $error("filtered edge without steady pin");
endmodule

// [test/dtcc_top_test.sv]
`timescale 1ns/1ps
module dtcc_top_test;
	logic        clk, reset, psel, penable, pwrite, hso, ext, pready, perr, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  event_link_unit;
	logic [3:0]  ccp_in, ccp_out, ccp_oe;
	int          err_count, comparisons;
	dtcc_top i_dtcc_top (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.HSO_TICK(hso), .EXT_CLK_PIN(ext), .EVENT_LINK_IN(event_link_unit), .CCP_IN(ccp_in), .CCP_OUT(ccp_out),
		.CCP_OE(ccp_oe), .IRQ(irq));
	// free clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; nothing is released before pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		report_and_stop;
	end
	initial begin
		{reset, psel, penable, pwrite, hso, ext, event_link_unit, ccp_in, paddr, pwdata} = '0;
		reset = 1'b1;
		err_count = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rdchk(dtcc_pkg::OFS_START, 32'hc);
		rdchk(dtcc_pkg::OFS_GRA0, 32'hffff);
		// counter write lands on one channel only unless synced
		wr(dtcc_pkg::OFS_CNT0, 32'h1234);
		rdchk(dtcc_pkg::OFS_CNT1, 32'h0);
		wr(dtcc_pkg::OFS_MODE, 32'h1);
		wr(dtcc_pkg::OFS_CNT1, 32'h55);
		rdchk(dtcc_pkg::OFS_CNT0, 32'h55);
		wr(dtcc_pkg::OFS_MODE, 32'h0);
		// captures on stopped counters give an exact expected value
		wr(dtcc_pkg::OFS_IOC0, 32'h3);
		wr(dtcc_pkg::OFS_CNT0, 32'h42);
		ccp_in <= 4'h3;
		repeat (6) @(posedge clk);
		rdchk(dtcc_pkg::OFS_GRA0, 32'h42);
		rdchk(dtcc_pkg::OFS_GRB0, 32'h42);
		rdchk(dtcc_pkg::OFS_STAT, 32'h3);
		wr(dtcc_pkg::OFS_IOC1, 32'h41);
		wr(dtcc_pkg::OFS_CNT1, 32'h77);
		event_link_unit <= 2'h2;
		@(posedge clk);
		event_link_unit <= 2'h0;
		rdchk(dtcc_pkg::OFS_GRA1, 32'h77);
		#1 check({31'h0, irq}, 32'h0);
		wr(dtcc_pkg::OFS_MASK, 32'h8);
		#1 check({31'h0, irq}, 32'h1);
		wr(dtcc_pkg::OFS_STAT, 32'h9);
		#1 check({31'h0, irq}, 32'h0);
		wr(dtcc_pkg::OFS_IOC1, 32'h0);
		// clear on match A at 3: toggle every 4 ticks
		wr(dtcc_pkg::OFS_CTRL0, 32'h1);
		wr(dtcc_pkg::OFS_GRA0, 32'h3);
		wr(dtcc_pkg::OFS_IOC0, 32'h180);
		wr(dtcc_pkg::OFS_CNT0, 32'h0);
		wr(dtcc_pkg::OFS_START, 32'hd);
		repeat (9) @(posedge clk);
		#1 check({31'h0, ccp_out[0]}, 32'h0);
		check({31'h0, ccp_oe[0]}, 32'h1);
		repeat (4) @(posedge clk);
		#1 check({31'h0, ccp_out[0]}, 32'h1);
		repeat (4) @(posedge clk);
		#1 check({31'h0, ccp_out[0]}, 32'h0);
		// stop select 0 halts at match A, clears run and keeps the match level
		wr(dtcc_pkg::OFS_START, 32'hc);
		wr(dtcc_pkg::OFS_CTRL0, 32'h0);
		wr(dtcc_pkg::OFS_GRA0, 32'h5);
		wr(dtcc_pkg::OFS_CNT0, 32'h0);
		wr(dtcc_pkg::OFS_IOC0, 32'h80);
		wr(dtcc_pkg::OFS_START, 32'h9);
		repeat (20) @(posedge clk);
		rdchk(dtcc_pkg::OFS_CNT0, 32'h5);
		rdchk(dtcc_pkg::OFS_START, 32'h8);
		check({31'h0, ccp_out[0]}, 32'h0);
		// free-run wrap sets the overflow flag; match A at 5 drives the pin high
		wr(dtcc_pkg::OFS_IOC0, 32'h100);
		wr(dtcc_pkg::OFS_CNT0, 32'hfff0);
		wr(dtcc_pkg::OFS_MASK, 32'h4);
		wr(dtcc_pkg::OFS_START, 32'hd);
		repeat (30) @(posedge clk);
		#1 check({31'h0, irq}, 32'h1);
		check({31'h0, ccp_out[0]}, 32'h1);
		wr(dtcc_pkg::OFS_START, 32'hc);
		wr(dtcc_pkg::OFS_STAT, 32'h3f);
		#1 check({31'h0, irq}, 32'h0);
		// oscillator tick and external pin sources, five ticks each
		for (int s = 5; s <= 6; s++) begin
			wr(dtcc_pkg::OFS_CTRL0, 32'(s) << dtcc_pkg::CKS_POS);
			wr(dtcc_pkg::OFS_CNT0, 32'h0);
			wr(dtcc_pkg::OFS_START, 32'hd);
			repeat (5) begin
				hso <= 1'b1;
				ext <= 1'b1;
				@(posedge clk);
				hso <= 1'b0;
				repeat (4) @(posedge clk);
				ext <= 1'b0;
				repeat (4) @(posedge clk);
			end
			wr(dtcc_pkg::OFS_START, 32'hc);
			rdchk(dtcc_pkg::OFS_CNT0, 32'h5);
		end
		// divide by 32: 64 running cycles hold exactly two ticks whatever the prescaler phase
		wr(dtcc_pkg::OFS_CTRL0, 32'h20);
		wr(dtcc_pkg::OFS_CNT0, 32'h0);
		wr(dtcc_pkg::OFS_START, 32'hd);
		repeat (61) @(posedge clk);
		wr(dtcc_pkg::OFS_START, 32'hc);
		rdchk(dtcc_pkg::OFS_CNT0, 32'h2);
		// the filter drops a one-cycle glitch and passes a steady edge
		wr(dtcc_pkg::OFS_IOC0, 32'h801);
		wr(dtcc_pkg::OFS_CNT0, 32'h99);
		ccp_in <= 4'h2;
		repeat (6) @(posedge clk);
		ccp_in <= 4'h3;
		@(posedge clk);
		ccp_in <= 4'h2;
		repeat (6) @(posedge clk);
		rdchk(dtcc_pkg::OFS_GRA0, 32'h5);
		ccp_in <= 4'h3;
		repeat (6) @(posedge clk);
		rdchk(dtcc_pkg::OFS_GRA0, 32'h99);
		xfer(1'b0, 8'h40, 32'h0);
		check({31'h0, perr}, 32'h1);
		report_and_stop;
	end
endmodule
